// *** dsgsr_core_model.sv ***
/*
 Model of the core side that probes port accesses for the gating block.
 Assumes one clock shared with the block and an active-low async reset.
*/
module dsgsr_core_model (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       go,
    input  wire logic [2:0] goPort,
    output logic            accStrobe,
    output logic [2:0]      accPort
);
    timeunit 1ns;
    timeprecision 100ps;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            accStrobe <= 1'b0;
            accPort   <= 3'h0;
        end else if (go) begin
            accStrobe <= 1'b1;
            accPort   <= goPort;
        end else begin
            accStrobe <= 1'b0;
            // Released index toggles each idle cycle, so the stale port comes back every second cycle
            accPort   <= ~accPort;
        end
    end
endmodule // dsgsr_core_model

// *** dsgsr_gate_sel.sv ***
/*
 Picks the gating set that applies in the current power mode.
 Assumes the control module drives the carrier from its own flops.
*/
module dsgsr_gate_sel (
    dsgsr_sel_if.sel sel
);
    always_comb begin
        // Without auto gating the run set persists in every mode
        if (!sel.autoGate) begin
            sel.gate = sel.runGate;
        end else begin
            case (sel.mode)
                dsgsr_pkg::DSGSR_SLEEP: sel.gate = sel.sleepGate;
                dsgsr_pkg::DSGSR_DEEP:  sel.gate = sel.deepGate;
                default:                sel.gate = sel.runGate;
            endcase
        end
    end
endmodule // dsgsr_gate_sel

// *** dsgsr_params.svh ***
/*
 Offsets, field positions, reset values and widths of the deep-sleep
 gating and soft reset block. Assumes inclusion by its bare name.
*/
`ifndef DSGSR_PARAMS_SVH
`define DSGSR_PARAMS_SVH

`define DSGSR_ADDR_W          12
`define DSGSR_OFF_SRCR        12'h040
`define DSGSR_OFF_RUN_CFG     12'h060
`define DSGSR_OFF_RUN_GATE    12'h108
`define DSGSR_OFF_SLEEP_GATE  12'h118
`define DSGSR_OFF_DEEP_GATE   12'h128
`define DSGSR_OFF_IRQ_STAT    12'h200
`define DSGSR_OFF_IRQ_MASK    12'h204

`define DSGSR_NUM_PORTS       8
`define DSGSR_AUTO_GATE_BIT   0
`define DSGSR_PWM_BIT         20
`define DSGSR_ADC_BIT         16
`define DSGSR_HIBERN_BIT      6
`define DSGSR_WATCHDOG_BIT    3
`define DSGSR_SRCR_VALID      32'h0011_0048

`define DSGSR_IRQ_FAULT_BIT   0
`define DSGSR_IRQ_MASKED_BIT  1
`define DSGSR_IRQ_W           2

`define DSGSR_GATE_RESET      8'h00
`define DSGSR_SRCR_RESET      32'h0000_0000
`define DSGSR_AUTO_GATE_RESET 1'h0
`define DSGSR_IRQ_RESET       2'h0

`endif

// *** dsgsr_pkg.sv ***
/*
 Types of the deep-sleep gating and soft reset block.
 Assumes dsgsr_params.svh is on the include path.
*/
`include "dsgsr_params.svh"

package dsgsr_pkg;

    typedef enum logic [1:0] {
        DSGSR_RUN   = 2'b00,
        DSGSR_SLEEP = 2'b01,
        DSGSR_DEEP  = 2'b10
    } dsgsr_mode_t;

    typedef logic [`DSGSR_NUM_PORTS-1:0] dsgsr_gate_t;

    typedef struct packed {
        dsgsr_mode_t                mode;
        dsgsr_gate_t                runGate;
        dsgsr_gate_t                sleepGate;
        dsgsr_gate_t                deepGate;
        logic                       autoGate;
        logic [31:0]                srcr;
        dsgsr_gate_t                portEn;
        logic [31:0]                rdata;
        logic                       busFault;
        logic [`DSGSR_IRQ_W-1:0]    irqStat;
        logic [`DSGSR_IRQ_W-1:0]    irqMask;
        logic                       irq;
    } dsgsr_state_t;

endpackage

// *** dsgsr_sel_if.sv ***
/*
 Carrier between the control module and the gate selector.
 Assumes dsgsr_pkg is compiled first.
*/
interface dsgsr_sel_if;
    dsgsr_pkg::dsgsr_gate_t runGate;
    dsgsr_pkg::dsgsr_gate_t sleepGate;
    dsgsr_pkg::dsgsr_gate_t deepGate;
    dsgsr_pkg::dsgsr_mode_t mode;
    logic                   autoGate;
    dsgsr_pkg::dsgsr_gate_t gate;

    modport ctl (
        output runGate,
        output sleepGate,
        output deepGate,
        output mode,
        output autoGate,
        input  gate
    );
    modport sel (
        input  runGate,
        input  sleepGate,
        input  deepGate,
        input  mode,
        input  autoGate,
        output gate
    );
endinterface

// *** dsgsr_tb_top.sv ***
/*
 Self-checking bench for the gating and soft reset block.
 Assumes dsgsr_params.svh on the include path and the core model.
*/
`include "dsgsr_params.svh"

module dsgsr_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                      clock;
    logic                      rstn;
    logic                      clkEn;
    logic [`DSGSR_ADDR_W-1:0]  addr;
    logic [31:0]               wdata;
    logic                      wrEn;
    logic                      rdEn;
    logic [31:0]               rdata;
    logic                      sleepReq;
    logic                      deepReq;
    logic [31:0]               capMask;
    logic                      accStrobe;
    logic [2:0]                accPort;
    logic                      busFault;
    logic [7:0]                portClockEn;
    logic                      pwmReset;
    logic                      adcReset;
    logic                      hibernationReset;
    logic                      watchdogReset;
    logic                      irq;
    logic                      go;
    logic [2:0]                goPort;
    int                        failCount;
    int                        comparisons;
    int                        bitPos [4] = '{20, 16, 6, 3};

    dsgsr_top u_dut (
        .clock       (clock),
        .rstn        (rstn),
        .clkEn       (clkEn),
        .addr        (addr),
        .wdata       (wdata),
        .wrEn        (wrEn),
        .rdEn        (rdEn),
        .rdata       (rdata),
        .sleepReq    (sleepReq),
        .deepReq     (deepReq),
        .capMask     (capMask),
        .accStrobe   (accStrobe),
        .accPort     (accPort),
        .busFault    (busFault),
        .portClockEn (portClockEn),
        .pwmReset    (pwmReset),
        .adcReset    (adcReset),
        .hibernationReset (hibernationReset),
        .watchdogReset    (watchdogReset),
        .irq         (irq)
    );

    dsgsr_core_model u_core (
        .clock     (clock),
        .rstn      (rstn),
        .go        (go),
        .goPort    (goPort),
        .accStrobe (accStrobe),
        .accPort   (accPort)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wrEn  <= 1'b1;
        @(posedge clock);
        wrEn  <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clock);
        rdEn <= 1'b0;
        @(negedge clock);
        chk(rdata, exp);
    endtask

    // Probe through the core model; fault shows two edges after go
    task automatic access(input logic [2:0] p, input logic expFault);
        @(posedge clock);
        go     <= 1'b1;
        goPort <= p;
        @(posedge clock);
        go     <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        chk(32'(busFault), 32'(expFault));
    endtask

    task automatic settle();
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        failCount++;
        printVerdict();
    end

    initial begin
        failCount = 0;
        comparisons = 0;
        rstn = 1'b0;
        clkEn = 1'b1;
        addr = 12'h000;
        wdata = 32'h0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        sleepReq = 1'b0;
        deepReq = 1'b0;
        capMask = 32'hFFFFFFFF;
        go = 1'b0;
        goPort = 3'h0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk(32'({irq, busFault, pwmReset, adcReset, hibernationReset,
                 watchdogReset, portClockEn}), 32'h0);
        rd(`DSGSR_OFF_DEEP_GATE, 32'h0);
        rd(`DSGSR_OFF_SRCR, 32'h0);
        rd(`DSGSR_OFF_RUN_GATE, 32'h0);
        rd(`DSGSR_OFF_SLEEP_GATE, 32'h0);
        access(3'h0, 1'b1);
        chk(32'(irq), 32'h0);
        rd(`DSGSR_OFF_IRQ_STAT, 32'h1);
        wr(`DSGSR_OFF_IRQ_STAT, 32'h1);
        rd(`DSGSR_OFF_IRQ_STAT, 32'h0);
        wr(`DSGSR_OFF_IRQ_MASK, 32'hFFFFFFFF);
        rd(`DSGSR_OFF_IRQ_MASK, 32'h3);
        wr(`DSGSR_OFF_RUN_GATE, 32'h3C);
        wr(`DSGSR_OFF_SLEEP_GATE, 32'hC3);
        wr(`DSGSR_OFF_DEEP_GATE, 32'hFFFFFFFF);
        rd(`DSGSR_OFF_DEEP_GATE, 32'hFF);
        wr(`DSGSR_OFF_DEEP_GATE, 32'h5A);
        settle();
        chk(32'(portClockEn), 32'h3C);
        access(3'h2, 1'b0);
        access(3'h0, 1'b1);
        chk(32'(irq), 32'h1);
        wr(`DSGSR_OFF_IRQ_STAT, 32'h3);
        settle();
        chk(32'(irq), 32'h0);
        @(posedge clock);
        deepReq <= 1'b1;
        settle();
        chk(32'(portClockEn), 32'h3C);
        wr(`DSGSR_OFF_RUN_CFG, 32'h1);
        settle();
        chk(32'(portClockEn), 32'h5A);
        access(3'h1, 1'b0);
        access(3'h2, 1'b1);
        wr(`DSGSR_OFF_IRQ_STAT, 32'h3);
        for (int i = 0; i < 8; i++) begin
            wr(`DSGSR_OFF_DEEP_GATE, 32'h1 << i);
            settle();
            chk(32'(portClockEn), 32'h1 << i);
        end
        @(posedge clock);
        deepReq  <= 1'b0;
        sleepReq <= 1'b1;
        settle();
        chk(32'(portClockEn), 32'hC3);
        @(posedge clock);
        sleepReq <= 1'b0;
        settle();
        chk(32'(portClockEn), 32'h3C);
        wr(`DSGSR_OFF_SRCR, 32'hFFFFFFFF);
        rd(`DSGSR_OFF_SRCR, 32'h00110048);
        settle();
        chk(32'({pwmReset, adcReset, hibernationReset, watchdogReset}),
            32'hF);
        for (int k = 0; k < 4; k++) begin
            wr(`DSGSR_OFF_SRCR, 32'h1 << bitPos[k]);
            settle();
            chk(32'({pwmReset, adcReset, hibernationReset, watchdogReset}),
                32'h8 >> k);
        end
        wr(`DSGSR_OFF_SRCR, 32'h00100000);
        @(posedge clock);
        capMask <= ~32'h00100000;
        wr(`DSGSR_OFF_SRCR, 32'h0);
        rd(`DSGSR_OFF_SRCR, 32'h00100000);
        chk(32'(pwmReset), 32'h1);
        rd(`DSGSR_OFF_IRQ_STAT, 32'h2);
        @(posedge clock);
        capMask <= 32'hFFFFFFFF;
        wr(`DSGSR_OFF_SRCR, 32'h0);
        settle();
        chk(32'(pwmReset), 32'h0);
        // Frozen cycles must not take a write
        @(posedge clock);
        clkEn <= 1'b0;
        wr(`DSGSR_OFF_RUN_GATE, 32'h00);
        @(posedge clock);
        clkEn <= 1'b1;
        rd(`DSGSR_OFF_RUN_GATE, 32'h3C);
        // Mid-run reset must clear gates, soft resets and irq
        wr(`DSGSR_OFF_SRCR, 32'h00000048);
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk(32'({irq, busFault, pwmReset, adcReset, hibernationReset,
                 watchdogReset, portClockEn}), 32'h0);
        rd(`DSGSR_OFF_RUN_GATE, 32'h0);
        rd(`DSGSR_OFF_SRCR, 32'h0);
        wr(12'h300, 32'hFFFFFFFF);
        rd(12'h300, 32'h0);
        printVerdict();
    end
endmodule // dsgsr_tb_top

// *** dsgsr_top.sv ***
/*
 Deep-sleep port clock gating and first soft reset control, with
 run and sleep gating sets, auto gating bit, fault check and interrupt.
 Assumes register bus, mode requests and access probes are synchronous
 to clock; capability mask is a static level from the same domain.
*/
`include "dsgsr_params.svh"

module dsgsr_top #(
    parameter int ADDR_W = `DSGSR_ADDR_W
) (
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              clkEn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wrEn,
    input  wire logic              rdEn,
    output logic      [31:0]       rdata,
    input  wire logic              sleepReq,
    input  wire logic              deepReq,
    input  wire logic [31:0]       capMask,
    input  wire logic              accStrobe,
    input  wire logic [2:0]        accPort,
    output logic                   busFault,
    output logic      [7:0]        portClockEn,
    output logic                   pwmReset,
    output logic                   adcReset,
    output logic                   hibernationReset,
    output logic                   watchdogReset,
    output logic                   irq
);

    generate
        if (ADDR_W < `DSGSR_ADDR_W) begin : g_bad_addr
            $error("dsgsr_top: ADDR_W too narrow for the register map");
        end
    endgenerate

    dsgsr_pkg::dsgsr_state_t st_reg;
    dsgsr_pkg::dsgsr_state_t st_next;

    dsgsr_sel_if selBus ();

    assign selBus.runGate   = st_reg.runGate;
    assign selBus.sleepGate = st_reg.sleepGate;
    assign selBus.deepGate  = st_reg.deepGate;
    assign selBus.mode      = st_reg.mode;
    assign selBus.autoGate  = st_reg.autoGate;

    dsgsr_gate_sel u_sel (
        .sel (selBus.sel)
    );

    logic [11:0] regAddr;
    logic        upperZero;
    logic [31:0] srcrWe;
    logic [31:0] readMux;
    logic        maskedEvt;
    logic        faultEvt;
    logic [`DSGSR_IRQ_W-1:0] irqSet;
    logic [`DSGSR_IRQ_W-1:0] irqClr;

    assign regAddr = addr[11:0];

    generate
        if (ADDR_W > 12) begin : g_upper
            assign upperZero = (addr[ADDR_W-1:12] == '0);
        end else begin : g_no_upper
            assign upperZero = 1'b1;
        end
    endgenerate

    // Only bits of units present on the part may change
    assign srcrWe = capMask & `DSGSR_SRCR_VALID;

    always_comb begin
        readMux = 32'h0000_0000;
        if (!upperZero) begin
            readMux = 32'h0000_0000;
        end else if (regAddr == `DSGSR_OFF_SRCR) begin
            readMux = st_reg.srcr & `DSGSR_SRCR_VALID;
        end else if (regAddr == `DSGSR_OFF_RUN_CFG) begin
            readMux[`DSGSR_AUTO_GATE_BIT] = st_reg.autoGate;
        end else if (regAddr == `DSGSR_OFF_RUN_GATE) begin
            readMux[7:0] = st_reg.runGate;
        end else if (regAddr == `DSGSR_OFF_SLEEP_GATE) begin
            readMux[7:0] = st_reg.sleepGate;
        end else if (regAddr == `DSGSR_OFF_DEEP_GATE) begin
            readMux[7:0] = st_reg.deepGate;
        end else if (regAddr == `DSGSR_OFF_IRQ_STAT) begin
            readMux[`DSGSR_IRQ_W-1:0] = st_reg.irqStat;
        end else if (regAddr == `DSGSR_OFF_IRQ_MASK) begin
            readMux[`DSGSR_IRQ_W-1:0] = st_reg.irqMask;
        end
    end

    // Fault judged against the gate actually applied this cycle
    assign faultEvt  = accStrobe && !st_reg.portEn[accPort];
    assign maskedEvt = wrEn && upperZero && (regAddr == `DSGSR_OFF_SRCR)
                       && (((wdata ^ st_reg.srcr) & `DSGSR_SRCR_VALID
                            & ~capMask) != 32'h0000_0000);

    always_comb begin
        irqSet = '0;
        irqSet[`DSGSR_IRQ_FAULT_BIT]  = faultEvt;
        irqSet[`DSGSR_IRQ_MASKED_BIT] = maskedEvt;
        irqClr = '0;
        if (wrEn && upperZero && regAddr == `DSGSR_OFF_IRQ_STAT) begin
            irqClr = wdata[`DSGSR_IRQ_W-1:0];
        end
    end

    always_comb begin
        st_next = st_reg;

        // Deep request outranks sleep request
        case (st_reg.mode)
            dsgsr_pkg::DSGSR_RUN: begin
                if (deepReq) begin
                    st_next.mode = dsgsr_pkg::DSGSR_DEEP;
                end else if (sleepReq) begin
                    st_next.mode = dsgsr_pkg::DSGSR_SLEEP;
                end
            end
            dsgsr_pkg::DSGSR_SLEEP: begin
                if (deepReq) begin
                    st_next.mode = dsgsr_pkg::DSGSR_DEEP;
                end else if (!sleepReq) begin
                    st_next.mode = dsgsr_pkg::DSGSR_RUN;
                end
            end
            dsgsr_pkg::DSGSR_DEEP: begin
                if (!deepReq) begin
                    st_next.mode = sleepReq ? dsgsr_pkg::DSGSR_SLEEP
                                            : dsgsr_pkg::DSGSR_RUN;
                end
            end
            default: st_next.mode = dsgsr_pkg::DSGSR_RUN;
        endcase

        if (wrEn && upperZero) begin
            if (regAddr == `DSGSR_OFF_SRCR) begin
                st_next.srcr = (st_reg.srcr & ~srcrWe)
                             | (wdata & srcrWe);
            end else if (regAddr == `DSGSR_OFF_RUN_CFG) begin
                st_next.autoGate = wdata[`DSGSR_AUTO_GATE_BIT];
            end else if (regAddr == `DSGSR_OFF_RUN_GATE) begin
                st_next.runGate = wdata[7:0];
            end else if (regAddr == `DSGSR_OFF_SLEEP_GATE) begin
                st_next.sleepGate = wdata[7:0];
            end else if (regAddr == `DSGSR_OFF_DEEP_GATE) begin
                st_next.deepGate = wdata[7:0];
            end else if (regAddr == `DSGSR_OFF_IRQ_MASK) begin
                st_next.irqMask = wdata[`DSGSR_IRQ_W-1:0];
            end
        end

        // Read data stands only in the cycle after the strobe
        st_next.rdata = rdEn ? readMux : 32'h0000_0000;

        st_next.portEn   = selBus.gate;
        st_next.busFault = faultEvt;

        // Set wins over a simultaneous write-one clear
        st_next.irqStat = (st_reg.irqStat & ~irqClr) | irqSet;
        st_next.irq     = |(st_next.irqStat & st_next.irqMask);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg.mode      <= dsgsr_pkg::DSGSR_RUN;
            st_reg.runGate   <= `DSGSR_GATE_RESET;
            st_reg.sleepGate <= `DSGSR_GATE_RESET;
            st_reg.deepGate  <= `DSGSR_GATE_RESET;
            st_reg.autoGate  <= `DSGSR_AUTO_GATE_RESET;
            st_reg.srcr      <= `DSGSR_SRCR_RESET;
            st_reg.portEn    <= `DSGSR_GATE_RESET;
            st_reg.rdata     <= 32'h0000_0000;
            st_reg.busFault  <= 1'b0;
            st_reg.irqStat   <= `DSGSR_IRQ_RESET;
            st_reg.irqMask   <= `DSGSR_IRQ_RESET;
            st_reg.irq       <= 1'b0;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign rdata       = st_reg.rdata;
    assign busFault    = st_reg.busFault;
    assign portClockEn = st_reg.portEn;
    // Unit held in reset as long as its bit stays set
    assign pwmReset    = st_reg.srcr[`DSGSR_PWM_BIT];
    assign adcReset    = st_reg.srcr[`DSGSR_ADC_BIT];
    assign hibernationReset = st_reg.srcr[`DSGSR_HIBERN_BIT];
    assign watchdogReset    = st_reg.srcr[`DSGSR_WATCHDOG_BIT];
    assign irq         = st_reg.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    logic srcrWr;
    assign srcrWr = clkEn && wrEn && upperZero && regAddr == `DSGSR_OFF_SRCR;

    property p_deep_gate;
        clkEn && st_reg.autoGate && st_reg.mode == dsgsr_pkg::DSGSR_DEEP
        |=> portClockEn == $past(st_reg.deepGate);
    endproperty
    a_deep_gate: assert property (p_deep_gate)
        else $error("deep-sleep gate not applied");

    property p_fault;
        clkEn && accStrobe && !portClockEn[accPort] |=> busFault;
    endproperty
    a_fault: assert property (p_fault)
        else $error("gated access gave no fault");

    property p_no_fault;
        clkEn && accStrobe && portClockEn[accPort] |=> !busFault;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("clocked access gave a fault");

    property p_reset_zero;
        $rose(rstn) |-> portClockEn == 8'h00 && st_reg.deepGate == 8'h00;
    endproperty
    a_reset_zero: assert property (@(posedge clock) p_reset_zero)
        else $error("gating not zero after reset");

    property p_sleep_gate;
        clkEn && st_reg.autoGate && st_reg.mode == dsgsr_pkg::DSGSR_SLEEP
        |=> portClockEn == $past(st_reg.sleepGate);
    endproperty
    a_sleep_gate: assert property (p_sleep_gate)
        else $error("sleep gate not applied");

    property p_run_persist;
        clkEn && !st_reg.autoGate |=> portClockEn == $past(st_reg.runGate);
    endproperty
    a_run_persist: assert property (p_run_persist)
        else $error("run gate not kept without auto gating");

    property p_deep_upper;
        clkEn && rdEn && upperZero && regAddr == `DSGSR_OFF_DEEP_GATE
        |=> rdata[31:8] == 24'h00_0000 && rdata[7:0] == $past(st_reg.deepGate);
    endproperty
    a_deep_upper: assert property (p_deep_upper)
        else $error("deep gate read wrong");

    property p_cap_mask;
        srcrWr |=> ((st_reg.srcr ^ $past(st_reg.srcr)) & ~$past(capMask))
                   == 32'h0000_0000;
    endproperty
    a_cap_mask: assert property (p_cap_mask)
        else $error("masked soft reset bit changed");

    property p_pwm;
        srcrWr && capMask[`DSGSR_PWM_BIT]
        |=> pwmReset == $past(wdata[`DSGSR_PWM_BIT]);
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("PWM reset not following write");

    property p_adc;
        srcrWr && capMask[`DSGSR_ADC_BIT]
        |=> adcReset == $past(wdata[`DSGSR_ADC_BIT]);
    endproperty
    a_adc: assert property (p_adc)
        else $error("ADC reset not following write");

    property p_hibernation;
        srcrWr && capMask[`DSGSR_HIBERN_BIT]
        |=> hibernationReset == $past(wdata[`DSGSR_HIBERN_BIT]);
    endproperty
    a_hibernation: assert property (p_hibernation)
        else $error("hibernation reset not following write");

    property p_watchdog_reserved;
        srcrWr |=> watchdogReset == ($past(capMask[`DSGSR_WATCHDOG_BIT])
                ? $past(wdata[`DSGSR_WATCHDOG_BIT]) : $past(watchdogReset))
                   && (st_reg.srcr & ~`DSGSR_SRCR_VALID) == 32'h0000_0000;
    endproperty
    a_watchdog_reserved: assert property (p_watchdog_reserved)
        else $error("watchdog reset or reserved bits wrong");

    property p_hold;
        !srcrWr && !$past(srcrWr) && pwmReset |=> pwmReset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset released without a write");

    property p_cov_deep_fault;
        st_reg.mode == dsgsr_pkg::DSGSR_DEEP && st_reg.autoGate ##1 busFault;
    endproperty
    c_deep_fault: cover property (p_cov_deep_fault);

    property p_cov_reset_cycle;
        pwmReset ##[1:20] !pwmReset;
    endproperty
    c_reset_cycle: cover property (p_cov_reset_cycle);

    property p_cov_irq;
        irq ##1 !irq;
    endproperty
    c_irq: cover property (p_cov_irq);

endmodule // dsgsr_top
